// File: rtl/pio_top.sv
/*
  Parallel I/O port block: data and direction registers for ports A to D,
  port A pullups and keyboard input enables, on a classic Wishbone slave.
  Assumes pins are resolved outside from value, output enable and pullup.
*/
// The Wishbone interface to the registers was chosen for this implementation.
// Summary of operation
// - Port A has four bidirectional keyboard-capable pins.
// - Each pin has latch; direction bit steers it.
// - Reset leaves port A latches untouched.
// - Direction one drives pin, zero releases.
// - Reset clears port A direction bits.
// - Output pin reads back its latch.
// - Input pin reads back synchronised pin level.
// - Latch writes always accepted, any direction.
// - Pullup enable on input turns pullup on.
// - No pullup, input: high impedance pin.
// - Output pins always have pullup off.
// - Keyboard enables route pins to keyboard module.
// - Ports B, C, D directions reset zero.
// - Ports B, C, D latches survive reset.
module pio_top
  import pio_pkg::*;
#(
  parameter int A_WIDTH = PIO_A_WIDTH,
  parameter int B_WIDTH = PIO_B_WIDTH,
  parameter int C_WIDTH = PIO_C_WIDTH,
  parameter int D_WIDTH = PIO_D_WIDTH
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [5:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Port A pins
  input wire logic [A_WIDTH-1:0] i_pa,
  output logic [A_WIDTH-1:0] o_pa,
  output logic [A_WIDTH-1:0] o_pa_oe,
  output logic [A_WIDTH-1:0] o_pa_pullup,
  // Keyboard module inputs
  output logic [A_WIDTH-1:0] o_keyboard_inputs,
  output logic [A_WIDTH-1:0] o_keyboard_irq_enable_bits,
  // Port B pins
  input wire logic [B_WIDTH-1:0] i_pb,
  output logic [B_WIDTH-1:0] o_pb,
  output logic [B_WIDTH-1:0] o_pb_oe,
  // Port C pins
  input wire logic [C_WIDTH-1:0] i_pc,
  output logic [C_WIDTH-1:0] o_pc,
  output logic [C_WIDTH-1:0] o_pc_oe,
  // Port D pins
  input wire logic [D_WIDTH-1:0] i_pd,
  output logic [D_WIDTH-1:0] o_pd,
  output logic [D_WIDTH-1:0] o_pd_oe
);
  // ==========================================================================
  // Register state.
  typedef struct packed {
    logic [A_WIDTH-1:0] dir_a;
    logic [B_WIDTH-1:0] dir_b;
    logic [C_WIDTH-1:0] dir_c;
    logic [D_WIDTH-1:0] dir_d;
    logic [A_WIDTH-1:0] pullup_a;
    logic [A_WIDTH-1:0] kbd_en;
    logic ack;
    logic [31:0] rdata;
  } pio_state_t;

  pio_state_t state_reg;
  pio_state_t state_next;

  logic [A_WIDTH-1:0] rd_a;
  logic [B_WIDTH-1:0] rd_b;
  logic [C_WIDTH-1:0] rd_c;
  logic [D_WIDTH-1:0] rd_d;
  logic [A_WIDTH-1:0] lvl_a;
  logic [3:0] idx;
  logic req;
  logic wr;
  logic [7:0] wbyte;

  assign idx = i_wb_adr[5:2];
  assign req = i_wb_cyc && i_wb_stb && !state_reg.ack;
  // Registers live in byte lane 0; writes without that lane are ignored.
  assign wr = req && i_wb_we && i_wb_sel[0];
  assign wbyte = i_wb_dat[7:0];

  // ==========================================================================
  // Bus decode and register update.
  always_comb begin
    state_next = state_reg;
    state_next.ack = req;
    if (wr) begin
      case (idx)
        PIO_IDX_A_DIR: state_next.dir_a = wbyte[A_WIDTH-1:0];
        PIO_IDX_B_DIR: state_next.dir_b = wbyte[B_WIDTH-1:0];
        PIO_IDX_C_DIR: state_next.dir_c = wbyte[C_WIDTH-1:0];
        PIO_IDX_D_DIR: state_next.dir_d = wbyte[D_WIDTH-1:0];
        PIO_IDX_A_PULLUP: state_next.pullup_a = wbyte[A_WIDTH-1:0];
        PIO_IDX_KBD_ENABLE: state_next.kbd_en = wbyte[A_WIDTH-1:0];
        default: state_next.ack = req;
      endcase
    end
    state_next.rdata = 32'h0000_0000;
    if (req && !i_wb_we) begin
      case (idx)
        PIO_IDX_A_DATA: state_next.rdata[A_WIDTH-1:0] = rd_a;
        PIO_IDX_B_DATA: state_next.rdata[B_WIDTH-1:0] = rd_b;
        PIO_IDX_C_DATA: state_next.rdata[C_WIDTH-1:0] = rd_c;
        PIO_IDX_D_DATA: state_next.rdata[D_WIDTH-1:0] = rd_d;
        PIO_IDX_A_DIR: state_next.rdata[A_WIDTH-1:0] = state_reg.dir_a;
        PIO_IDX_B_DIR: state_next.rdata[B_WIDTH-1:0] = state_reg.dir_b;
        PIO_IDX_C_DIR: state_next.rdata[C_WIDTH-1:0] = state_reg.dir_c;
        PIO_IDX_D_DIR: state_next.rdata[D_WIDTH-1:0] = state_reg.dir_d;
        PIO_IDX_A_PULLUP: state_next.rdata[A_WIDTH-1:0] = state_reg.pullup_a;
        PIO_IDX_KBD_ENABLE: state_next.rdata[A_WIDTH-1:0] = state_reg.kbd_en;
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg.dir_a <= PIO_DIR_RESET[A_WIDTH-1:0];
      state_reg.dir_b <= PIO_DIR_RESET[B_WIDTH-1:0];
      state_reg.dir_c <= PIO_DIR_RESET[C_WIDTH-1:0];
      state_reg.dir_d <= PIO_DIR_RESET[D_WIDTH-1:0];
      state_reg.pullup_a <= PIO_PULLUP_RESET[A_WIDTH-1:0];
      state_reg.kbd_en <= PIO_KBD_ENABLE_RESET[A_WIDTH-1:0];
      state_reg.ack <= 1'b0;
      state_reg.rdata <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_wb_ack = state_reg.ack;
  assign o_wb_dat = state_reg.rdata;

  // ==========================================================================
  // Ports.
  pio_pin #(.WIDTH(A_WIDTH)) u_port_a (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_latch_we(wr && idx == PIO_IDX_A_DATA),
    .i_latch_wdata(wbyte[A_WIDTH-1:0]),
    .i_dir(state_reg.dir_a),
    .i_pullup_en(state_reg.pullup_a),
    .o_rdata(rd_a),
    .o_pin_level(lvl_a),
    .i_pin(i_pa),
    .o_pin(o_pa),
    .o_pin_oe(o_pa_oe),
    .o_pullup_on(o_pa_pullup)
  );

  pio_pin #(.WIDTH(B_WIDTH)) u_port_b (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_latch_we(wr && idx == PIO_IDX_B_DATA),
    .i_latch_wdata(wbyte[B_WIDTH-1:0]),
    .i_dir(state_reg.dir_b),
    .i_pullup_en({B_WIDTH{1'b0}}),
    .o_rdata(rd_b),
    .o_pin_level(),
    .i_pin(i_pb),
    .o_pin(o_pb),
    .o_pin_oe(o_pb_oe),
    .o_pullup_on()
  );

  pio_pin #(.WIDTH(C_WIDTH)) u_port_c (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_latch_we(wr && idx == PIO_IDX_C_DATA),
    .i_latch_wdata(wbyte[C_WIDTH-1:0]),
    .i_dir(state_reg.dir_c),
    .i_pullup_en({C_WIDTH{1'b0}}),
    .o_rdata(rd_c),
    .o_pin_level(),
    .i_pin(i_pc),
    .o_pin(o_pc),
    .o_pin_oe(o_pc_oe),
    .o_pullup_on()
  );

  pio_pin #(.WIDTH(D_WIDTH)) u_port_d (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_latch_we(wr && idx == PIO_IDX_D_DATA),
    .i_latch_wdata(wbyte[D_WIDTH-1:0]),
    .i_dir(state_reg.dir_d),
    .i_pullup_en({D_WIDTH{1'b0}}),
    .o_rdata(rd_d),
    .o_pin_level(),
    .i_pin(i_pd),
    .o_pin(o_pd),
    .o_pin_oe(o_pd_oe),
    .o_pullup_on()
  );

  // Keyboard module sees the synchronised level of each enabled pin only.
  assign o_keyboard_irq_enable_bits = state_reg.kbd_en;
  assign o_keyboard_inputs = lvl_a & state_reg.kbd_en;
endmodule

// File: rtl/pio_pkg.sv
/*
  Package for the parallel I/O port block: register indices, port widths,
  and reset values of the direction, pullup and keyboard enable registers.
  Assumes a 32-bit classic Wishbone slave with one register per word.
*/
package pio_pkg;
  // ==========================================================================
  // Register indices (byte address is four times the index).
  localparam logic [3:0] PIO_IDX_A_DATA = 4'h0;
  localparam logic [3:0] PIO_IDX_B_DATA = 4'h1;
  localparam logic [3:0] PIO_IDX_C_DATA = 4'h2;
  localparam logic [3:0] PIO_IDX_D_DATA = 4'h3;
  localparam logic [3:0] PIO_IDX_A_DIR = 4'h4;
  localparam logic [3:0] PIO_IDX_B_DIR = 4'h5;
  localparam logic [3:0] PIO_IDX_C_DIR = 4'h6;
  localparam logic [3:0] PIO_IDX_D_DIR = 4'h7;
  localparam logic [3:0] PIO_IDX_A_PULLUP = 4'h8;
  localparam logic [3:0] PIO_IDX_KBD_ENABLE = 4'h9;
  // ==========================================================================
  // Port widths.
  localparam int PIO_A_WIDTH = 4;
  localparam int PIO_B_WIDTH = 6;
  localparam int PIO_C_WIDTH = 2;
  localparam int PIO_D_WIDTH = 7;
  // ==========================================================================
  // Reset values.
  localparam logic [7:0] PIO_DIR_RESET = 8'h00;
  localparam logic [7:0] PIO_PULLUP_RESET = 8'h00;
  localparam logic [7:0] PIO_KBD_ENABLE_RESET = 8'h00;
endpackage

// File: rtl/pio_pin.sv
/*
  One port of bidirectional pins: synchroniser, data latch without reset,
  and per-pin driver/pullup control.
  Assumes the data latch write strobe comes from the bus slave on i_mclk.
*/
module pio_pin
  import pio_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Register side
  input wire logic i_latch_we,
  input wire logic [WIDTH-1:0] i_latch_wdata,
  input wire logic [WIDTH-1:0] i_dir,
  input wire logic [WIDTH-1:0] i_pullup_en,
  output logic [WIDTH-1:0] o_rdata,
  output logic [WIDTH-1:0] o_pin_level,
  // Pins
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_pin,
  output logic [WIDTH-1:0] o_pin_oe,
  output logic [WIDTH-1:0] o_pullup_on
);
  // ==========================================================================
  // State.
  typedef struct packed {
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
  } pio_pin_sync_t;

  pio_pin_sync_t sync_reg;
  pio_pin_sync_t sync_next;
  logic [WIDTH-1:0] latch_reg;

  always_comb begin
    sync_next.sync1 = i_pin;
    sync_next.sync2 = sync_reg.sync1;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // The latch has no reset: its contents survive a reset on purpose.
  always_ff @(posedge i_mclk) begin
    if (i_latch_we) begin
      latch_reg <= i_latch_wdata;
    end
  end

  // ==========================================================================
  // Pin control and read-back.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      o_rdata[i] = i_dir[i] ? latch_reg[i] : sync_reg.sync2[i];
    end
  end

  assign o_pin = latch_reg;
  assign o_pin_oe = i_dir;
  assign o_pullup_on = i_pullup_en & ~i_dir;
  assign o_pin_level = sync_reg.sync2;
endmodule

// File: bench/pio_board.sv
/*
  Board model for the port A pins.
  Assumes the bench sets the board level and whether the board drives.
*/
module pio_board (
  // Clock
  input wire logic i_clk,
  // Device side
  input wire logic [3:0] i_val,
  input wire logic [3:0] i_oe,
  input wire logic [3:0] i_pu,
  // Board side
  input wire logic i_drive,
  input wire logic [3:0] i_lvl,
  output logic [3:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Pin resolution
  // A floating pin toggles every cycle, so no read of it can pass by luck.
  logic flip = 1'h0;
  always @(posedge i_clk) flip <= ~flip;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (i_oe[k]) o_pin[k] = i_val[k];
      else if (i_drive) o_pin[k] = i_lvl[k];
      else if (i_pu[k]) o_pin[k] = 1'h1;
      else o_pin[k] = flip;
    end
  end
endmodule

// File: bench/pio_top_asserts.sv
/*
  Assertions on the top ports of the parallel port block.
  Assumes the bind below; only port A pins are watched.
*/
module pio_top_asserts #(
  parameter int A_WIDTH = 4
) (
  // Clock, reset and bus
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [5:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Port A
  input wire logic [A_WIDTH-1:0] o_pa,
  input wire logic [A_WIDTH-1:0] o_pa_oe,
  input wire logic [A_WIDTH-1:0] o_pa_pullup,
  input wire logic [A_WIDTH-1:0] o_keyboard_inputs,
  input wire logic [A_WIDTH-1:0] o_keyboard_irq_enable_bits
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // ==========
  // Properties
  logic take;
  logic wr0;
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr0 = take && i_wb_we && i_wb_sel[0];
  ack_next_a: assert property (take |=> o_wb_ack) else $error("ack missing after request");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
  upper_zero_a: assert property (o_wb_ack && i_wb_adr[5:2] == 4'h0 |-> o_wb_dat[31:A_WIDTH] == '0)
    else $error("port A read has upper bits set");
  dir_drive_a: assert property (wr0 && i_wb_adr[5:2] == 4'h4 |=> o_pa_oe == $past(i_wb_dat[A_WIDTH-1:0]))
    else $error("output enable differs from written direction");
  latch_load_a: assert property (wr0 && i_wb_adr[5:2] == 4'h0 |=> o_pa == $past(i_wb_dat[A_WIDTH-1:0]))
    else $error("pin value differs from written latch");
  pullup_off_a: assert property ((o_pa_pullup & o_pa_oe) == '0) else $error("pullup on a driven pin");
  kbd_gate_a: assert property ((o_keyboard_inputs & ~o_keyboard_irq_enable_bits) == '0)
    else $error("keyboard input passes while disabled");
  dir_reset_a: assert property ($rose(i_arst_n) |-> o_pa_oe == '0) else $error("pin driven after reset");
endmodule

bind pio_top pio_top_asserts #(.A_WIDTH(A_WIDTH)) i_chk (
  .i_mclk, .i_arst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
  .o_pa, .o_pa_oe, .o_pa_pullup, .o_keyboard_inputs, .o_keyboard_irq_enable_bits
);

// File: bench/test_pio_top.sv
/*
  Self-checking bench for the parallel port block over classic Wishbone.
  Assumes the board model resolves port A; ports B to D inputs are held here.
*/
module test_pio_top
  import pio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic drv = 1'h1;
  logic ack;
  logic [5:0] adr = 6'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] pa, pa_o, pa_oe, pa_pu, kin, ken;
  logic [5:0] pb_o, pb_oe;
  logic [6:0] pd_o;
  logic [7:0] pinv [4] = '{8'h0A, 8'h15, 8'h01, 8'h2A};
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o, rdat;
  logic [7:0] msk [4] = '{8'h0F, 8'h3F, 8'h03, 8'h7F};
  int bad_count = 0;
  int num_checks = 0;
  pio_top i_dut (.i_mclk(clk), .i_arst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(dat_o), .o_wb_ack(ack), .i_pa(pa), .o_pa(pa_o), .o_pa_oe(pa_oe),
    .o_pa_pullup(pa_pu), .o_keyboard_inputs(kin), .o_keyboard_irq_enable_bits(ken), .i_pb(6'h15), .o_pb(pb_o),
    .o_pb_oe(pb_oe), .i_pc(2'h1), .o_pc(), .o_pc_oe(), .i_pd(7'h2A), .o_pd(pd_o), .o_pd_oe());
  pio_board i_board (.i_clk(clk), .i_val(pa_o), .i_oe(pa_oe), .i_pu(pa_pu), .i_drive(drv), .i_lvl(4'hA), .o_pin(pa));
  always #2.5 clk = ~clk;
  // ==========
  // Bus tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bus(input logic [3:0] idx, input logic w, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    sel <= s;
    adr <= {idx, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    rdat = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 50) begin
      bad_count++;
      $display("BAD ack expected 1 seen timeout");
      end_sim();
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    bus(idx, 1'h1, d, 4'h1);
  endtask
  // Pins need two synchroniser edges, so each read waits for them first.
  task automatic rd(input string nm, input logic [3:0] idx, input logic [31:0] e);
    repeat (3) @(posedge clk);
    bus(idx, 1'h0, 8'h00, 4'hF);
    chk(nm, e, rdat);
  endtask
  // ==========
  // Tests
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 4; i < 10; i++) rd("reset value", 4'(i), 32'h0);
    $display("test reset done");
    wr(PIO_IDX_A_DATA, 8'h05);
    rd("pa input", PIO_IDX_A_DATA, 32'hA);
    wr(PIO_IDX_A_DIR, 8'hFF);
    chk("pa drive", 32'h5, {28'h0, pa_o});
    rd("pa output", PIO_IDX_A_DATA, 32'h5);
    rd("pa dir", PIO_IDX_A_DIR, 32'hF);
    wr(PIO_IDX_A_DIR, 8'h03);
    wr(PIO_IDX_A_DATA, 8'hFF);
    rd("pa mixed", PIO_IDX_A_DATA, 32'hB);
    wr(PIO_IDX_A_PULLUP, 8'hFF);
    drv <= 1'h0;
    chk("pullup", 32'hC, {28'h0, pa_pu});
    wr(PIO_IDX_A_DIR, 8'h00);
    rd("pulled", PIO_IDX_A_DATA, 32'hF);
    wr(PIO_IDX_A_PULLUP, 8'h00);
    chk("no pullup", 32'h0, {24'h0, pa_pu, pa_oe});
    drv <= 1'h1;
    wr(PIO_IDX_KBD_ENABLE, 8'h03);
    repeat (4) @(posedge clk);
    chk("kbd", 32'h32, {24'h0, ken, kin});
    $display("test port a done");
    for (int i = 1; i < 4; i++) begin
      wr(4'(i), 8'hFF);
      wr(4'(i + 4), 8'hFF);
      rd("port data", 4'(i), {24'h0, msk[i]});
    end
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    chk("pb after reset", 32'h3F, {26'h0, pb_o});
    chk("pd after reset", 32'h7F, {25'h0, pd_o});
    chk("pb oe after reset", 32'h0, {26'h0, pb_oe});
    for (int i = 0; i < 4; i++) begin
      rd("dir after reset", 4'(i + 4), 32'h0);
      rd("pin after reset", 4'(i), {24'h0, pinv[i]});
      wr(4'(i + 4), 8'hFF);
      rd("data after reset", 4'(i), {24'h0, msk[i]});
    end
    wr(4'hC, 8'hFF);
    rd("unmapped", 4'hC, 32'h0);
    bus(PIO_IDX_B_DATA, 1'h1, 8'h00, 4'h0);
    rd("sel off", PIO_IDX_B_DATA, 32'h3F);
    $display("test ports done");
    end_sim();
  end
endmodule
